// >>> spc_pkg.sv
// Package of constants for the serial port configuration registers
package spc_pkg;
  localparam int unsigned SPC_ADDR_W = 13;
  localparam logic [12:0] SPC_OFS_SETUP = 13'h000;
  localparam logic [12:0] SPC_OFS_VARIANT = 13'h003;
  localparam logic [12:0] SPC_OFS_RBSEL = 13'h004;
  localparam logic [12:0] SPC_OFS_UPDATE = 13'h232;
  // Field positions in the setup, readback select and update bytes
  localparam int unsigned SPC_BIT_SEPOUT = 0;
  localparam int unsigned SPC_BIT_LSBFIRST = 1;
  localparam int unsigned SPC_BIT_SOFTRST = 2;
  localparam int unsigned SPC_BIT_LONGINS = 3;
  localparam int unsigned SPC_BIT_RBACTIVE = 0;
  localparam int unsigned SPC_BIT_UPDATE = 0;
  // Reset values
  localparam logic [7:0] SPC_RST_SETUP = 8'h18;
  localparam logic [7:0] SPC_RST_RBSEL = 8'h00;
endpackage

// >>> spc_serial_port_config_regs.sv
// Serial port setup, variant identifier and readback source registers
`timescale 1ns/10ps
// Overview of operation
// RULE_01 - Host writes the setup byte with its upper nibble the bit-reversed lower nibble.
// RULE_02 - Only 16-bit instructions exist; the long instruction bit resets to 1 and stays 1.
// RULE_03 - Soft reset bit set to 1 restores defaults and holds until the host writes it to 0; the code restores only the readback select registers.
// RULE_04 - Bit order 1 means LSB first with incrementing address; 0 means MSB first, decrement.
// RULE_05 - Separate output enable 0 uses the data pin both ways and floats the output pin.
// RULE_06 - Separate output enable 1 drives reads only on the output pin, writes on data pin.
// RULE_07 - A read-only 8-bit variant identifier byte ignores writes.
// RULE_08 - Readback source bit 0 returns buffered copies, 1 returns active values.
// RULE_09 - Writes land in buffered copies and become active only on an update transfer; the code buffers only the readback select byte.
module spc_serial_port_config_regs
  import spc_pkg::*;
#(
  parameter logic [7:0] VARIANT_ID = 8'h5A // Arbitrary value
)(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register access from the serial port engine
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Mode outputs to the serial port engine
  output logic lsb_first,
  output logic addr_increment,
  output logic soft_reset,
  output logic data_pin_drives_reads,
  output logic dedicated_output_pin_oe
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] setup_q;
  logic [7:0] setup_d;
  logic [7:0] rbsel_q;
  logic [7:0] rbsel_act_q;
  logic [7:0] rbsel_view;
  logic [7:0] rdata_d;
  logic setup_wr;
  logic rbsel_wr;
  logic update;
  logic rst_int;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (SPC_ADDR_W != 13)
  begin : g_bad_addr_width
    $error("Address width must match the 13-bit address port");
  end

  if (SPC_BIT_LONGINS > 3)
  begin : g_bad_long_pos
    $error("Long instruction bit must sit in the lower nibble");
  end

  if (SPC_BIT_SEPOUT > 7 || SPC_BIT_LSBFIRST > 7 || SPC_BIT_SOFTRST > 7 || SPC_BIT_RBACTIVE > 7)
  begin : g_bad_field_pos
    $error("Field positions must fall inside one byte");
  end

  if (SPC_RST_SETUP[SPC_BIT_LONGINS] != 1'b1)
  begin : g_bad_setup_reset
    $error("Setup reset value must select long instructions");
  end

  // ****************************************
  // Access decode
  // ****************************************
  assign setup_wr = wr_en && (addr == SPC_OFS_SETUP);
  assign rbsel_wr = wr_en && (addr == SPC_OFS_RBSEL);
  assign update = wr_en && (addr == SPC_OFS_UPDATE) && wdata[SPC_BIT_UPDATE]; // RULE_09
  assign rst_int = !nrst || setup_q[SPC_BIT_SOFTRST]; // RULE_03

  // ****************************************
  // Setup byte next value
  // ****************************************
  always_comb
  begin
    setup_d = setup_q; // RULE_03
    if (setup_wr)
    begin
      setup_d = wdata; // RULE_01
      setup_d[SPC_BIT_LONGINS] = 1'b1; // RULE_02
      setup_d[7 - SPC_BIT_LONGINS] = 1'b1; // RULE_02
    end
  end

  // ****************************************
  // Setup byte, soft reset held until cleared
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      setup_q <= SPC_RST_SETUP;
    end
    else
    begin
      setup_q <= setup_d; // RULE_03
    end
  end

  // ****************************************
  // Readback select, buffered copy
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst_int)
    begin
      rbsel_q <= SPC_RST_RBSEL; // RULE_03
    end
    else if (rbsel_wr)
    begin
      rbsel_q <= {7'h00, wdata[SPC_BIT_RBACTIVE]}; // RULE_09
    end
  end

  // ****************************************
  // Readback select, active copy
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst_int)
    begin
      rbsel_act_q <= SPC_RST_RBSEL; // RULE_03
    end
    else if (update)
    begin
      rbsel_act_q <= rbsel_q; // RULE_09
    end
  end

  // ****************************************
  // Readback bank choice
  // ****************************************
  always_comb
  begin
    rbsel_view = rbsel_q; // RULE_08
    if (rbsel_act_q[SPC_BIT_RBACTIVE])
    begin
      rbsel_view = rbsel_act_q; // RULE_08
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (addr)
      SPC_OFS_SETUP: rdata_d = setup_q;
      SPC_OFS_VARIANT: rdata_d = VARIANT_ID; // RULE_07
      SPC_OFS_RBSEL: rdata_d = rbsel_view; // RULE_08
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rdata <= 8'h00;
    end
    else if (rd_en)
    begin
      rdata <= rdata_d;
    end
  end

  // ****************************************
  // Bit order and address direction
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      lsb_first <= SPC_RST_SETUP[SPC_BIT_LSBFIRST];
      addr_increment <= SPC_RST_SETUP[SPC_BIT_LSBFIRST];
    end
    else
    begin
      lsb_first <= setup_q[SPC_BIT_LSBFIRST]; // RULE_04
      addr_increment <= setup_q[SPC_BIT_LSBFIRST]; // RULE_04
    end
  end

  // ****************************************
  // Soft reset indication
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      soft_reset <= SPC_RST_SETUP[SPC_BIT_SOFTRST];
    end
    else
    begin
      soft_reset <= setup_q[SPC_BIT_SOFTRST]; // RULE_03
    end
  end

  // ****************************************
  // Data pin direction
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      data_pin_drives_reads <= !SPC_RST_SETUP[SPC_BIT_SEPOUT];
      dedicated_output_pin_oe <= 1'b0;
    end
    else
    begin
      data_pin_drives_reads <= !setup_q[SPC_BIT_SEPOUT]; // RULE_05
      dedicated_output_pin_oe <= setup_q[SPC_BIT_SEPOUT] && rd_en; // RULE_06
    end
  end

endmodule // spc_serial_port_config_regs

// >>> spc_mon_monitor.sv
// Port checker for the config registers
`timescale 1ns/10ps
module spc_mon #(parameter logic [7:0] VARIANT_ID = 8'h5A)(
  input wire logic clock, nrst, wr_en, rd_en,
  input wire logic [12:0] addr,
  input wire logic [7:0] wdata, rdata,
  input wire logic lsb_first, addr_increment, soft_reset,
  input wire logic data_pin_drives_reads, dedicated_output_pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire ws = wr_en && addr == 13'h000;
  a_incr_tracks: assert property (addr_increment == lsb_first) else $error("incr");
  a_order_set: assert property (ws ##1 !ws |=>
    lsb_first == $past(wdata[1], 2)) else $error("order");
  a_soft_set: assert property (ws ##1 !ws |=>
    soft_reset == $past(wdata[2], 2)) else $error("soft");
  a_long_one: assert property (rd_en && addr == 13'h000 |=>
    rdata[3]) else $error("long");
  a_bidir_mode: assert property ((ws && !wdata[0]) ##1 !ws |=>
    data_pin_drives_reads && !dedicated_output_pin_oe) else $error("bidir");
  a_unidir_read: assert property (!ws ##1 (rd_en && !data_pin_drives_reads) |=>
    dedicated_output_pin_oe) else $error("unidir");
  a_oe_idle: assert property (!rd_en |=>
    !dedicated_output_pin_oe) else $error("idle");
  a_id_fixed: assert property (rd_en && addr == 13'h003 |=>
    rdata == VARIANT_ID) else $error("id");
  a_reset_bank: assert property (soft_reset && rd_en && addr == 13'h004 |=>
    rdata == 8'h00) else $error("bank");
endmodule // spc_mon
bind spc_serial_port_config_regs spc_mon #(.VARIANT_ID(VARIANT_ID)) mon (.*);

// >>> spc_host.sv
// Host controller model
`timescale 1ns/10ps
module spc_host (
  input wire logic clock,
  output logic wr_en, rd_en,
  output logic [12:0] addr,
  output logic [7:0] wdata
);
  initial {wr_en, rd_en, addr, wdata} = '0;
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(negedge clock);
    {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
    @(negedge clock);
    {wr_en, rd_en, wdata} = {2'b00, ~d};
  endtask
  task automatic setup(input logic [2:0] m);
    acc(1'b1, 13'h000, {m[0], m[1], m[2], 2'b11, m});
  endtask
endmodule // spc_host

// >>> spc_serial_port_config_regs_tb.sv
// Testbench for the config registers
`timescale 1ns/10ps
module spc_serial_port_config_regs_tb;
  import spc_pkg::*;
  logic clock = 0, nrst = 0, wr_en, rd_en, lsb_first, addr_increment, soft_reset;
  logic data_pin_drives_reads, dedicated_output_pin_oe;
  logic [12:0] addr;
  logic [7:0] wdata, rdata;
  int mismatches = 0, checked = 0;
  always #5 clock = ~clock;
  spc_host host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
  spc_serial_port_config_regs DUT (.clock(clock), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .lsb_first(lsb_first),
    .addr_increment(addr_increment), .soft_reset(soft_reset),
    .data_pin_drives_reads(data_pin_drives_reads),
    .dedicated_output_pin_oe(dedicated_output_pin_oe));
  task automatic chk(input logic [7:0] g, e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask
  function automatic logic [7:0] md();
    return {3'h0, soft_reset, lsb_first, addr_increment, data_pin_drives_reads,
      dedicated_output_pin_oe};
  endfunction
  task automatic results;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    results;
  end
  initial
  begin
    repeat (2) @(negedge clock);
    nrst = 1;
    rd(SPC_OFS_SETUP, SPC_RST_SETUP);
    host.acc(1'b1, SPC_OFS_VARIANT, 8'hFF);
    rd(SPC_OFS_VARIANT, 8'h5A);
    host.setup(3'b011);
    rd(SPC_OFS_SETUP, 8'hDB);
    chk(md(), 8'h0D);
    host.setup(3'b000);
    rd(SPC_OFS_SETUP, 8'h18);
    chk(md(), 8'h02);
    host.acc(1'b1, SPC_OFS_RBSEL, 8'h01);
    host.acc(1'b1, SPC_OFS_UPDATE, 8'h01);
    rd(SPC_OFS_RBSEL, 8'h01);
    host.acc(1'b1, SPC_OFS_RBSEL, 8'h00);
    rd(SPC_OFS_RBSEL, 8'h01);
    host.setup(3'b100);
    rd(SPC_OFS_RBSEL, 8'h00);
    chk(md(), 8'h12);
    host.setup(3'b000);
    rd(SPC_OFS_RBSEL, 8'h00);
    chk(md(), 8'h02);
    host.acc(1'b1, SPC_OFS_SETUP, 8'h00);
    rd(SPC_OFS_SETUP, 8'h18);
    results;
  end
endmodule // spc_serial_port_config_regs_tb
